// *** hdl/wbm_top.sv ***
// Purpose: Wake-up timer and battery monitor with host register port
// Assumes: Register port strobes are synchronous single-cycle requests
// Notes: Status bits clear when status 2 is read; a same-cycle event wins
//
// Contract
// - Supply is digitised as a 5-bit code.
// - Battery level register shows the latest code while monitoring is enabled.
// - Code below threshold with its enable set drives the interrupt pin low.
// - Code means 1.7 V plus 50 mV per count, 0 and 31 saturate.
// - Monitor powers detector once per second for about 250 us.
// - Low battery event needs four consecutive low readings.
// - Timer runs from the internal RC oscillator by default.
// - Timer enabled on sleep entry counts the period and flags expiry.
// - Period is 32 times M times 2^(R-D) slow ticks.
// - Running 16-bit count readable at any time in two registers.
// - Enabled timer expiry drives interrupt low and requests the fast crystal.
// - Disabled timer interrupt with IO routing signals expiry on the pin only.
// - External slow crystal select reconfigures the first IO pin.
// - With that select, timer and clock output use the external crystal.
// - Monitor enabled in sleep starts the RC oscillator by itself.
`timescale 1ns/100ps
`default_nettype none
module wbm_top (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic sleep_mode,
  input wire logic rc_tick,
  input wire logic xtal32_tick,
  input wire logic [4:0] battery_code_in,
  input wire logic wut_to_io,
  output logic interrupt_request_pin_n,
  output logic battery_monitor_power,
  output logic rc_osc_en,
  output logic first_io_pin_xtal_mode,
  output logic slow_clk_from_xtal,
  output logic xtal30_start,
  output logic wut_io_out
);
  wbm_link_if lk ();

  logic [7:0] period_reg;
  logic [7:0] mant_hi_reg;
  logic [7:0] mant_lo_reg;
  logic [4:0] thresh_reg;
  logic en_wut_reg;
  logic en_lbd_reg;
  logic bm_en_reg;
  logic wt_en_reg;
  logic xsel_reg;
  logic flag_wut_reg;
  logic flag_lbd_reg;
  logic wt_run_reg;
  logic sleep_d_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic irq_n_reg;
  logic xtal30_reg;
  logic wut_io_reg;
  logic rc_en_reg;
  logic wr_hit;
  logic rd_status2;
  logic sleep_entry;
  logic [7:0] rd_next;

  assign sleep_entry = sleep_mode && !sleep_d_reg;
  assign rd_status2 = reg_rd && reg_addr == wbm_pkg::ADDR_STATUS2;
  assign wr_hit = reg_wr;

  // Timer tick source follows the slow clock select
  assign lk.slow_tick = xsel_reg ? xtal32_tick : rc_tick;
  assign lk.wt_run = wt_run_reg;
  assign lk.wt_exp = period_reg[wbm_pkg::EXP_LSB +: 4];
  assign lk.wt_div = period_reg[wbm_pkg::DIV_LSB +: 2];
  assign lk.wt_mant = {mant_hi_reg, mant_lo_reg};
  assign lk.bm_en = bm_en_reg;
  assign lk.bm_thresh = thresh_reg;

  wbm_wake_timer u_timer (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .lk(lk.timer)
  );

  wbm_battery_monitor u_monitor (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .adc_code(battery_code_in),
    .lk(lk.monitor)
  );

  // Configuration registers
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      period_reg <= wbm_pkg::RST_PERIOD;
      mant_hi_reg <= wbm_pkg::RST_MANT;
      mant_lo_reg <= wbm_pkg::RST_MANT;
      thresh_reg <= wbm_pkg::RST_THRESH;
      en_wut_reg <= wbm_pkg::RST_IRQ_EN[1];
      en_lbd_reg <= wbm_pkg::RST_IRQ_EN[0];
      bm_en_reg <= 1'b0;
      wt_en_reg <= 1'b0;
      xsel_reg <= 1'b0;
    end else if (wr_hit) begin
      unique case (reg_addr)
        wbm_pkg::ADDR_WAKE_PERIOD_EXPONENT: period_reg <= {2'b00, reg_wdata[5:0]};
        wbm_pkg::ADDR_WAKE_MANTISSA_HIGH: mant_hi_reg <= reg_wdata;
        wbm_pkg::ADDR_WAKE_MANTISSA_LOW: mant_lo_reg <= reg_wdata;
        wbm_pkg::ADDR_BATTERY_THRESHOLD: thresh_reg <= reg_wdata[4:0];
        wbm_pkg::ADDR_IRQ_EN2: begin
          en_wut_reg <= reg_wdata[wbm_pkg::BIT_WUT];
          en_lbd_reg <= reg_wdata[wbm_pkg::BIT_LBD];
        end
        wbm_pkg::ADDR_OPCTRL1: begin
          bm_en_reg <= reg_wdata[wbm_pkg::BIT_EN_BM];
          wt_en_reg <= reg_wdata[wbm_pkg::BIT_EN_WT];
          xsel_reg <= reg_wdata[wbm_pkg::BIT_XSEL];
        end
        default: ;
      endcase
    end
  end

  // Timer run control: armed on sleep entry, dropped when disabled
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sleep_d_reg <= 1'b0;
      wt_run_reg <= 1'b0;
    end else begin
      sleep_d_reg <= sleep_mode;
      if (!wt_en_reg) begin
        wt_run_reg <= 1'b0;
      end else if (sleep_entry) begin
        wt_run_reg <= 1'b1;
      end
    end
  end

  // Sticky event flags; a same-cycle event wins over the read clear
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      flag_wut_reg <= 1'b0;
      flag_lbd_reg <= 1'b0;
    end else begin
      if (lk.wt_expired && en_wut_reg) begin
        flag_wut_reg <= 1'b1;
      end else if (rd_status2) begin
        flag_wut_reg <= 1'b0;
      end
      if (lk.bm_low_evt) begin
        flag_lbd_reg <= 1'b1;
      end else if (rd_status2) begin
        flag_lbd_reg <= 1'b0;
      end
    end
  end

  // Interrupt pin and wake actions
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      irq_n_reg <= 1'b1;
      xtal30_reg <= 1'b0;
      wut_io_reg <= 1'b0;
    end else begin
      irq_n_reg <= !((flag_lbd_reg && en_lbd_reg) || (flag_wut_reg && en_wut_reg));
      if (lk.wt_expired && en_wut_reg) begin
        xtal30_reg <= 1'b1;
      end else if (!sleep_mode) begin
        xtal30_reg <= 1'b0;
      end
      // Without the interrupt the state is left alone; only the pin reports
      if (lk.wt_expired && !en_wut_reg && wut_to_io) begin
        wut_io_reg <= 1'b1;
      end else if (rd_status2 || !wut_to_io) begin
        wut_io_reg <= 1'b0;
      end
    end
  end

  // Oscillator and pin routing
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rc_en_reg <= 1'b0;
    end else begin
      rc_en_reg <= sleep_mode && ((bm_en_reg) || (wt_en_reg && !xsel_reg));
    end
  end

  // Register read mux; unmapped addresses read zero
  always_comb begin
    rd_next = 8'h00;
    unique case (reg_addr)
      wbm_pkg::ADDR_STATUS1: rd_next = 8'h00;
      wbm_pkg::ADDR_STATUS2: begin
        rd_next[wbm_pkg::BIT_WUT] = flag_wut_reg;
        rd_next[wbm_pkg::BIT_LBD] = flag_lbd_reg;
      end
      wbm_pkg::ADDR_IRQ_EN2: begin
        rd_next[wbm_pkg::BIT_WUT] = en_wut_reg;
        rd_next[wbm_pkg::BIT_LBD] = en_lbd_reg;
      end
      wbm_pkg::ADDR_OPCTRL1: begin
        rd_next[wbm_pkg::BIT_EN_BM] = bm_en_reg;
        rd_next[wbm_pkg::BIT_EN_WT] = wt_en_reg;
        rd_next[wbm_pkg::BIT_XSEL] = xsel_reg;
      end
      wbm_pkg::ADDR_WAKE_PERIOD_EXPONENT: rd_next = period_reg;
      wbm_pkg::ADDR_WAKE_MANTISSA_HIGH: rd_next = mant_hi_reg;
      wbm_pkg::ADDR_WAKE_MANTISSA_LOW: rd_next = mant_lo_reg;
      wbm_pkg::ADDR_WAKE_COUNT_HIGH: rd_next = lk.wt_count[15:8];
      wbm_pkg::ADDR_WAKE_COUNT_LOW: rd_next = lk.wt_count[7:0];
      wbm_pkg::ADDR_BATTERY_THRESHOLD: rd_next = {3'b000, thresh_reg};
      // Code is raw: volts = 1.7 + 0.05 * code, ends saturate
      wbm_pkg::ADDR_BATTERY_LEVEL: rd_next = bm_en_reg ? {3'b000, lk.bm_code} : 8'h00;
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_rd;
      if (reg_rd) begin
        rdata_reg <= rd_next;
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign interrupt_request_pin_n = irq_n_reg;
  assign battery_monitor_power = lk.bm_power;
  assign rc_osc_en = rc_en_reg;
  assign first_io_pin_xtal_mode = xsel_reg;
  assign slow_clk_from_xtal = xsel_reg;
  assign xtal30_start = xtal30_reg;
  assign wut_io_out = wut_io_reg;
endmodule : wbm_top
`default_nettype wire

// *** hdl/wbm_pkg.sv ***
// Purpose: Constants and helpers for the wake-up timer and battery monitor
// Assumes: 10 MHz ref_clk, slow oscillator ticks arrive as one-cycle pulses
// Notes: Offsets are register port addresses
package wbm_pkg;
  localparam logic [6:0] ADDR_STATUS1 = 7'h03;
  localparam logic [6:0] ADDR_STATUS2 = 7'h04;
  localparam logic [6:0] ADDR_IRQ_EN2 = 7'h06;
  localparam logic [6:0] ADDR_OPCTRL1 = 7'h07;
  localparam logic [6:0] ADDR_WAKE_PERIOD_EXPONENT = 7'h14;
  localparam logic [6:0] ADDR_WAKE_MANTISSA_HIGH = 7'h15;
  localparam logic [6:0] ADDR_WAKE_MANTISSA_LOW = 7'h16;
  localparam logic [6:0] ADDR_WAKE_COUNT_HIGH = 7'h17;
  localparam logic [6:0] ADDR_WAKE_COUNT_LOW = 7'h18;
  localparam logic [6:0] ADDR_BATTERY_THRESHOLD = 7'h1a;
  localparam logic [6:0] ADDR_BATTERY_LEVEL = 7'h1b;

  // Field positions
  localparam int BIT_WUT = 3;
  localparam int BIT_LBD = 2;
  localparam int BIT_EN_BM = 6;
  localparam int BIT_EN_WT = 5;
  localparam int BIT_XSEL = 4;
  localparam int EXP_LSB = 2;
  localparam int DIV_LSB = 0;

  // Reset values
  localparam logic [7:0] RST_PERIOD = 8'h00;
  localparam logic [7:0] RST_MANT = 8'h00;
  localparam logic [4:0] RST_THRESH = 5'h14;
  localparam logic [1:0] RST_IRQ_EN = 2'h0;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int BM_WINDOW_NS = 250000;
  localparam int BM_WINDOW_CYC = BM_WINDOW_NS / CLK_PERIOD_NS;
  localparam int SLOW_TICKS_PER_S = 32768;
  localparam int BM_LOW_RUN = 4;
  localparam int BASE_SHIFT = 5;

  typedef enum logic [1:0] {
    WBM_BM_IDLE = 2'b00,
    WBM_BM_WAIT = 2'b01,
    WBM_BM_MEAS = 2'b10
  } wbm_bm_state_t;

  // Slow ticks per mantissa unit, less one: 32 * 2^(R-D) - 1
  function automatic logic [20:0] wbm_unit_limit(input logic [3:0] r, input logic [1:0] d);
    logic [4:0] sh;
    sh = 5'(BASE_SHIFT) + {1'b0, r} - {3'b000, d};
    return (21'h000001 << sh) - 21'h000001;
  endfunction : wbm_unit_limit
endpackage : wbm_pkg

// *** hdl/wbm_link_if.sv ***
// Purpose: Carrier between the control module and the timer and monitor
// Assumes: Single ref_clk domain
// Notes: None
`timescale 1ns/100ps
`default_nettype none
interface wbm_link_if;
  logic slow_tick;
  logic wt_run;
  logic [3:0] wt_exp;
  logic [1:0] wt_div;
  logic [15:0] wt_mant;
  logic wt_expired;
  logic [15:0] wt_count;
  logic bm_en;
  logic [4:0] bm_thresh;
  logic [4:0] bm_code;
  logic bm_low_evt;
  logic bm_power;
  modport ctrl(output slow_tick, wt_run, wt_exp, wt_div, wt_mant, bm_en, bm_thresh,
               input wt_expired, wt_count, bm_code, bm_low_evt, bm_power);
  modport timer(input slow_tick, wt_run, wt_exp, wt_div, wt_mant, output wt_expired, wt_count);
  modport monitor(input slow_tick, bm_en, bm_thresh, output bm_code, bm_low_evt, bm_power);
endinterface : wbm_link_if
`default_nettype wire

// *** hdl/wbm_wake_timer.sv ***
// Purpose: Wake-up period counter
// Assumes: slow_tick is one ref_clk cycle per slow oscillator period
// Notes: Mantissa of zero never expires
`timescale 1ns/100ps
`default_nettype none
module wbm_wake_timer (
  input wire logic ref_clk,
  input wire logic nrst,
  wbm_link_if.timer lk
);
  logic [20:0] unit_reg;
  logic [15:0] count_reg;
  logic exp_reg;
  logic [20:0] unit_lim;

  assign unit_lim = wbm_pkg::wbm_unit_limit(lk.wt_exp, lk.wt_div);

  always_ff @(posedge ref_clk) begin
    if (!nrst || !lk.wt_run) begin
      unit_reg <= 21'h000000;
      count_reg <= 16'h0000;
      exp_reg <= 1'b0;
    end else begin
      exp_reg <= 1'b0;
      if (lk.slow_tick) begin
        if (unit_reg >= unit_lim) begin
          unit_reg <= 21'h000000;
          if (count_reg + 16'h0001 == lk.wt_mant && lk.wt_mant != 16'h0000) begin
            count_reg <= 16'h0000;
            exp_reg <= 1'b1;
          end else begin
            count_reg <= count_reg + 16'h0001;
          end
        end else begin
          unit_reg <= unit_reg + 21'h000001;
        end
      end
    end
  end

  assign lk.wt_expired = exp_reg;
  assign lk.wt_count = count_reg;
endmodule : wbm_wake_timer
`default_nettype wire

// *** hdl/wbm_battery_monitor.sv ***
// Purpose: Periodic supply measurement and low-level filter
// Assumes: Converter code is valid at the end of the power window
// Notes: Low event fires once per run of low readings
`timescale 1ns/100ps
`default_nettype none
module wbm_battery_monitor (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [4:0] adc_code,
  wbm_link_if.monitor lk
);
  wbm_pkg::wbm_bm_state_t state_reg;
  logic [15:0] tick_reg;
  logic [11:0] win_reg;
  logic [4:0] code_reg;
  logic [2:0] run_reg;
  logic evt_reg;

  always_ff @(posedge ref_clk) begin
    if (!nrst || !lk.bm_en) begin
      state_reg <= wbm_pkg::WBM_BM_IDLE;
      tick_reg <= 16'h0000;
      win_reg <= 12'h000;
      code_reg <= 5'h00;
      run_reg <= 3'h0;
      evt_reg <= 1'b0;
    end else begin
      evt_reg <= 1'b0;
      unique case (state_reg)
        wbm_pkg::WBM_BM_IDLE: begin
          win_reg <= 12'h000;
          state_reg <= wbm_pkg::WBM_BM_MEAS; // First reading right after enable
        end
        wbm_pkg::WBM_BM_WAIT: begin
          if (lk.slow_tick) begin
            if (tick_reg == 16'(wbm_pkg::SLOW_TICKS_PER_S - 1)) begin
              tick_reg <= 16'h0000;
              win_reg <= 12'h000;
              state_reg <= wbm_pkg::WBM_BM_MEAS;
            end else begin
              tick_reg <= tick_reg + 16'h0001;
            end
          end
        end
        wbm_pkg::WBM_BM_MEAS: begin
          if (lk.slow_tick) begin
            tick_reg <= tick_reg + 16'h0001;
          end
          if (win_reg == 12'(wbm_pkg::BM_WINDOW_CYC - 1)) begin
            code_reg <= adc_code;
            state_reg <= wbm_pkg::WBM_BM_WAIT;
            if (adc_code < lk.bm_thresh) begin
              if (run_reg == 3'(wbm_pkg::BM_LOW_RUN - 1)) begin
                evt_reg <= 1'b1;
              end
              if (run_reg != 3'(wbm_pkg::BM_LOW_RUN)) begin
                run_reg <= run_reg + 3'h1;
              end
            end else begin
              run_reg <= 3'h0;
            end
          end else begin
            win_reg <= win_reg + 12'h001;
          end
        end
        default: state_reg <= wbm_pkg::WBM_BM_IDLE;
      endcase
    end
  end

  assign lk.bm_code = code_reg;
  assign lk.bm_low_evt = evt_reg;
  assign lk.bm_power = (state_reg == wbm_pkg::WBM_BM_MEAS);
endmodule : wbm_battery_monitor
`default_nettype wire

// *** test/wbm_top_props.sv ***
// Purpose: Port checks for the wake-up timer and battery monitor
// Assumes: Bound to wbm_top, one clock domain
// Notes: Power window length is counted in helper logic
`timescale 1ns/100ps
`default_nettype none
module wbm_top_props (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic sleep_mode,
  input wire logic wut_to_io,
  input wire logic battery_monitor_power,
  input wire logic rc_osc_en,
  input wire logic first_io_pin_xtal_mode,
  input wire logic wut_io_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [11:0] pw_reg;
  always_ff @(posedge ref_clk) begin
    if (!nrst || !battery_monitor_power) pw_reg <= 12'h000;
    else pw_reg <= pw_reg + 12'h001;
  end
  sequence rd_at(a);
    reg_rd && reg_addr == a;
  endsequence
  sequence wr_at(a);
    reg_wr && reg_addr == a;
  endsequence
  chk_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("read got no answer");
  chk_answer_cause: assert property (reg_rvalid |-> $past(reg_rd)) else $error("answer without read");
  chk_status_one: assert property (rd_at(7'h03) |=> reg_rdata == 8'h00) else $error("status 1 not zero");
  chk_level_width: assert property (rd_at(7'h1b) |=> reg_rdata[7:5] == 3'b000) else $error("level wider");
  chk_power_window: assert property ($fell(battery_monitor_power) |-> pw_reg == 12'h9c4)
    else $error("power window length wrong");
  chk_xsel_pin: assert property (wr_at(7'h07) |=> ##1 first_io_pin_xtal_mode == $past(reg_wdata[4], 2))
    else $error("io pin mode not following select");
  chk_rc_awake: assert property (!sleep_mode |=> !rc_osc_en) else $error("rc request outside sleep");
  chk_io_route: assert property (!wut_to_io |=> !wut_io_out) else $error("io expiry without routing");
endmodule : wbm_top_props
`default_nettype wire

// *** test/wbm_host_model.sv ***
// Purpose: Host model driving the register port
// Assumes: Single-cycle strobes, answer one cycle after a read
// Notes: Released write data shows the inverse so stale values never match
`timescale 1ns/100ps
`default_nettype none
module wbm_host_model (
  input wire logic ref_clk,
  output logic [6:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 7'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    d = reg_rvalid ? reg_rdata : 8'hxx;
  endtask : rd
  // Both status registers are read to confirm the event
  task automatic service(output logic [7:0] s1, output logic [7:0] s2);
    rd(7'h03, s1);
    rd(7'h04, s2);
  endtask : service
endmodule : wbm_host_model
`default_nettype wire

// *** test/tb_wakeup_timer_battery_monitor.sv ***
// Purpose: Self-checking bench for the wake-up timer and battery monitor
// Assumes: Slow ticks driven every cycle to shorten the one second period
// Notes: Random values from a fixed seed
`timescale 1ns/100ps
`default_nettype none
bind wbm_top wbm_top_props wbm_top_props_inst (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .sleep_mode(sleep_mode), .wut_to_io(wut_to_io), .battery_monitor_power(battery_monitor_power),
  .rc_osc_en(rc_osc_en), .first_io_pin_xtal_mode(first_io_pin_xtal_mode), .wut_io_out(wut_io_out));
module tb_wakeup_timer_battery_monitor;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic sleep_mode = 1'b0;
  logic rc_tick = 1'b1;
  logic xtal32_tick = 1'b0;
  logic wut_to_io = 1'b0;
  logic [4:0] code = 5'h00;
  wire logic [6:0] reg_addr;
  wire logic reg_wr, reg_rd, reg_rvalid, irq_n, bm_pwr, rc_en, io_xtal, from_xtal, xtal30, io_out;
  wire logic [7:0] reg_wdata, reg_rdata;
  int n_mismatch = 0;
  int tests_run = 0;
  int seed = 55261;
  wbm_top wbm_top_inst (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .sleep_mode(sleep_mode), .rc_tick(rc_tick), .xtal32_tick(xtal32_tick), .battery_code_in(code),
    .wut_to_io(wut_to_io), .interrupt_request_pin_n(irq_n), .battery_monitor_power(bm_pwr),
    .rc_osc_en(rc_en), .first_io_pin_xtal_mode(io_xtal), .slow_clk_from_xtal(from_xtal),
    .xtal30_start(xtal30), .wut_io_out(io_out));
  wbm_host_model wbm_host_model_inst (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  function automatic int exp_ticks(input logic [7:0] p, input int m);
    return ((32 * m) << p[5:2]) >> p[1:0];
  endfunction : exp_ticks
  // Bounded wait, so a dead pin ends as a mismatch rather than a hang
  task automatic wait_low(input int lim, output int n);
    n = 0;
    while (irq_n !== 1'b0 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : wait_low
  initial begin
    #(115000 * 100);
    n_mismatch++;
    finish_test();
  end
  initial begin
    logic [7:0] v, s1, s2;
    int n, t, m, thr;
    static logic [6:0] ra [9] = '{7'h03, 7'h06, 7'h07, 7'h14, 7'h15, 7'h16, 7'h1a, 7'h1b, 7'h20};
    static logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h14, 8'h00, 8'h00};
    static logic [7:0] cfg [3] = '{8'h00, 8'h05, 8'h04};
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      wbm_host_model_inst.rd(ra[i], v);
      chk("reset value", v, rv[i]);
    end
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      wbm_host_model_inst.wr(7'h16, v);
      wbm_host_model_inst.wr(7'h1a, v);
      wbm_host_model_inst.wr(7'h14, v);
      wbm_host_model_inst.wr(7'h1b, v);
      wbm_host_model_inst.rd(7'h16, s1);
      chk("mantissa", s1, v);
      wbm_host_model_inst.rd(7'h1a, s1);
      chk("threshold", s1, {3'b000, v[4:0]});
      wbm_host_model_inst.rd(7'h14, s1);
      chk("exponent", s1, v & 8'h3f);
      wbm_host_model_inst.rd(7'h1b, s1);
      chk("level idle", s1, 8'h00);
    end
    for (int i = 0; i < 3; i++) begin
      m = 1 + ($random(seed) & 1);
      t = exp_ticks(cfg[i], m);
      wbm_host_model_inst.wr(7'h14, cfg[i]); // Nonzero divisor only for the finer step
      wbm_host_model_inst.wr(7'h15, 8'h00);
      wbm_host_model_inst.wr(7'h16, 8'(m));
      wbm_host_model_inst.wr(7'h06, 8'h08);
      wbm_host_model_inst.wr(7'h07, 8'h20);
      sleep_mode <= 1'b1;
      wait_low(5000, n);
      chk("first expiry", 8'(n >= t && n <= t + 6), 8'h01);
      chk("fast crystal", {7'h00, xtal30}, 8'h01);
      wbm_host_model_inst.service(s1, s2);
      chk("wake status", s2, 8'h08);
      repeat (2) @(posedge ref_clk);
      chk("pin released", {7'h00, irq_n}, 8'h01);
      wbm_host_model_inst.rd(7'h18, v);
      chk("count low", 8'(v < t), 8'h01);
      wait_low(5000, n);
      chk("repeat expiry", 8'(n + 16 >= t && n <= t), 8'h01);
      wbm_host_model_inst.service(s1, s2);
      wbm_host_model_inst.rd(7'h17, v);
      chk("count high", v, 8'h00);
      sleep_mode <= 1'b0;
      wbm_host_model_inst.wr(7'h07, 8'h00);
    end
    wbm_host_model_inst.wr(7'h06, 8'h00);
    wbm_host_model_inst.wr(7'h07, 8'h30);
    rc_tick <= 1'b0;
    xtal32_tick <= 1'b1;
    wut_to_io <= 1'b1;
    sleep_mode <= 1'b1;
    n = 0;
    while (io_out !== 1'b1 && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    chk("io expiry", {7'h00, io_out}, 8'h01);
    chk("pin quiet", {7'h00, irq_n}, 8'h01);
    chk("state kept", {7'h00, xtal30}, 8'h00);
    chk("io crystal", {7'h00, io_xtal}, 8'h01);
    chk("slow source", {7'h00, from_xtal}, 8'h01);
    chk("rc unused", {7'h00, rc_en}, 8'h00);
    wut_to_io <= 1'b0;
    sleep_mode <= 1'b0;
    xtal32_tick <= 1'b0;
    rc_tick <= 1'b1;
    thr = 1 + ($unsigned($random(seed)) % 31);
    code <= 5'($unsigned($random(seed)) % thr);
    wbm_host_model_inst.wr(7'h07, 8'h00);
    wbm_host_model_inst.wr(7'h1a, 8'(thr));
    wbm_host_model_inst.wr(7'h06, 8'h04);
    wbm_host_model_inst.wr(7'h07, 8'h40);
    sleep_mode <= 1'b1;
    repeat (70000) @(posedge ref_clk);
    chk("rc in sleep", {7'h00, rc_en}, 8'h01);
    wbm_host_model_inst.rd(7'h1b, v);
    chk("level", v, {3'b000, code});
    chk("three low", {7'h00, irq_n}, 8'h01);
    wait_low(35000, n);
    chk("fourth low", {7'h00, irq_n}, 8'h00);
    wbm_host_model_inst.service(s1, s2);
    chk("battery status", s2, 8'h04);
    finish_test();
  end
endmodule : tb_wakeup_timer_battery_monitor
`default_nettype wire
